// ### rtl/pcc_pkg.sv
// Package for the pulse/period capture channel: register map, field layout,
// reset values and state encodings.
// Assumes a 32-bit AXI4-Lite register bus and 16-bit counter buses.
package pcc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CAP_A = 8'h08;
	localparam logic [7:0] OFS_CAP_B = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_TB_A_CTRL = 8'h14;
	localparam logic [7:0] OFS_TB_A_MATCH = 8'h18;
	localparam logic [7:0] OFS_TB_A_COUNT = 8'h1c;
	localparam logic [7:0] OFS_TB_B_CTRL = 8'h20;
	localparam logic [7:0] OFS_TB_B_MATCH = 8'h24;
	localparam logic [7:0] OFS_TB_B_COUNT = 8'h28;

	// Channel control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W = 4;
	localparam int CTRL_EDGE_POL_BIT = 7;
	localparam int CTRL_BUS_SEL_BIT = 8;

	// Status / mask fields
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_PIN_BIT = 1;

	// Timebase control fields
	localparam int TB_PRESCALE_LSB = 0;
	localparam int TB_PRESCALE_W = 8;
	localparam int TB_PRESCALE_EN_BIT = 8;
	localparam int TB_CTRL_W = 9;

	// Channel modes
	localparam logic [3:0] MODE_GP_INPUT = 4'h0;
	localparam logic [3:0] MODE_PULSE_WIDTH = 4'h1;
	localparam logic [3:0] MODE_PERIOD = 4'h2;

	// Reset values
	localparam logic [8:0] TB_CTRL_RST = 9'h000;
	localparam logic [15:0] MATCH_RST = 16'hffff;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// Input synchroniser depth
	localparam int SYNC_STAGES = 3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Capture sequencer
	typedef enum logic [1:0] {
		ST_FIRST = 2'h1,
		ST_SECOND = 2'h2
	} pcc_state_t;

endpackage

// ### rtl/pcc_mod_counter.sv
// Modulus up-counter that drives one shared counter bus.
// Assumes match and prescale settings come from registers on the same clock.
module pcc_mod_counter #(
	parameter int CNT_W = 16,
	parameter int PRE_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Settings
	input wire logic prescale_en,
	input wire logic [PRE_W-1:0] prescale_val,
	input wire logic [CNT_W-1:0] match_a,
	// Counter bus
	output logic [CNT_W-1:0] count
);

	typedef struct packed {
		logic [PRE_W-1:0] presc;
		logic [CNT_W-1:0] count;
	} pcc_cnt_state_t;

	pcc_cnt_state_t st_r;
	pcc_cnt_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (!prescale_en)
		begin
			// Counter holds while its prescaler is off
			st_nxt.presc = '0;
		end
		else if (st_r.presc >= prescale_val)
		begin
			st_nxt.presc = '0;
			// Wrap at match A; a lowered match also wraps at once
			if (st_r.count >= match_a)
				st_nxt.count = '0;
			else
				st_nxt.count = st_r.count + 1'b1;
		end
		else
		begin
			st_nxt.presc = st_r.presc + 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_r.presc <= '0;
			st_r.count <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.count;

endmodule // pcc_mod_counter

// ### rtl/pcc_channel.sv
// Pulse width / period capture channel with two modulus counter buses,
// an AXI4-Lite register slave and a level interrupt.
// Assumes pin_in is asynchronous to clk_sys; one clock, synchronous reset.
//
// Chosen here: the address map and the AXI4-Lite slave port.
module pcc_channel #(
	parameter int CNT_W = 16,
	parameter int PRE_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Measured input pin
	input wire logic pin_in,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Interrupt
	output logic irq
);

	typedef struct packed {
		logic [pcc_pkg::SYNC_STAGES-1:0] sync;
		logic pin_lvl;
		pcc_pkg::pcc_state_t state;
		logic [pcc_pkg::CTRL_MODE_W-1:0] mode;
		logic edge_polarity_select;
		logic bus_sel;
		logic [CNT_W-1:0] cap_a;
		logic [CNT_W-1:0] cap_b;
		logic channel_event_flag;
		logic irq_mask;
		logic irq;
		logic [pcc_pkg::TB_CTRL_W-1:0] tb_a_ctrl;
		logic [CNT_W-1:0] tb_a_match;
		logic [pcc_pkg::TB_CTRL_W-1:0] tb_b_ctrl;
		logic [CNT_W-1:0] tb_b_match;
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pcc_top_state_t;

	pcc_top_state_t st_r;
	pcc_top_state_t st_nxt;

	logic [CNT_W-1:0] bus_a;
	logic [CNT_W-1:0] bus_b;

	// Byte-lane merge of a write into a register image
	function automatic logic [31:0] pcc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	// Timebase control image as a bus word
	function automatic logic [31:0] pcc_tb_word(input logic [pcc_pkg::TB_CTRL_W-1:0] ctrl);
		return {{(32-pcc_pkg::TB_CTRL_W){1'b0}}, ctrl};
	endfunction

	// Counter bus A feeds channels by default
	pcc_mod_counter #(
		.CNT_W(CNT_W),
		.PRE_W(PRE_W)
	) u_bus_a (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.prescale_en(st_r.tb_a_ctrl[pcc_pkg::TB_PRESCALE_EN_BIT]),
		.prescale_val(st_r.tb_a_ctrl[pcc_pkg::TB_PRESCALE_LSB +: PRE_W]),
		.match_a(st_r.tb_a_match),
		.count(bus_a)
	);

	pcc_mod_counter #(
		.CNT_W(CNT_W),
		.PRE_W(PRE_W)
	) u_bus_b (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.prescale_en(st_r.tb_b_ctrl[pcc_pkg::TB_PRESCALE_EN_BIT]),
		.prescale_val(st_r.tb_b_ctrl[pcc_pkg::TB_PRESCALE_LSB +: PRE_W]),
		.match_a(st_r.tb_b_match),
		.count(bus_b)
	);

	always_comb
	begin
		logic [CNT_W-1:0] time_base;
		logic rise;
		logic fall;
		logic lead_edge;
		logic trail_edge;
		logic capture_done;
		logic do_write;
		logic [31:0] old_v;
		logic [31:0] new_v;
		logic [31:0] rd_v;
		logic rd_err;
		time_base = '0;
		rise = 1'b0;
		fall = 1'b0;
		lead_edge = 1'b0;
		trail_edge = 1'b0;
		capture_done = 1'b0;
		do_write = 1'b0;
		old_v = '0;
		new_v = '0;
		rd_v = '0;
		rd_err = 1'b0;
		st_nxt = st_r;

		// Three-stage synchroniser; level changes once stages two and three agree
		st_nxt.sync = {st_r.sync[pcc_pkg::SYNC_STAGES-2:0], pin_in};
		if (st_r.sync[1] == st_r.sync[2])
			st_nxt.pin_lvl = st_r.sync[2];
		rise = st_nxt.pin_lvl & ~st_r.pin_lvl;
		fall = ~st_nxt.pin_lvl & st_r.pin_lvl;

		time_base = st_r.bus_sel ? bus_b : bus_a;
		// Polarity set: leading edge rising, so a width is the high part
		lead_edge = st_r.edge_polarity_select ? rise : fall;
		trail_edge = st_r.edge_polarity_select ? fall : rise;

		// Capture sequencer
		case (st_r.state)
			pcc_pkg::ST_FIRST:
			begin
				if ((st_r.mode == pcc_pkg::MODE_PULSE_WIDTH || st_r.mode == pcc_pkg::MODE_PERIOD) && lead_edge)
				begin
					st_nxt.cap_b = time_base;
					st_nxt.state = pcc_pkg::ST_SECOND;
				end
			end
			pcc_pkg::ST_SECOND:
			begin
				if (st_r.mode == pcc_pkg::MODE_PULSE_WIDTH && trail_edge)
				begin
					st_nxt.cap_a = time_base;
					capture_done = 1'b1;
				end
				else if (st_r.mode == pcc_pkg::MODE_PERIOD && lead_edge)
				begin
					st_nxt.cap_a = time_base;
					capture_done = 1'b1;
				end
				if (capture_done)
					st_nxt.state = pcc_pkg::ST_FIRST;
			end
			default:
			begin
				st_nxt.state = pcc_pkg::ST_FIRST;
			end
		endcase

		// AXI write: address and data taken independently, then one response
		if (s_axi_awvalid && st_r.awready)
		begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready)
		begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
			st_nxt.wready = 1'b0;
		end
		if (st_r.bvalid && s_axi_bready)
		begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end
		do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
		if (do_write)
		begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = pcc_pkg::RESP_OKAY;
			if (st_r.awaddr == pcc_pkg::OFS_CTRL)
			begin
				old_v = '0;
				old_v[pcc_pkg::CTRL_MODE_LSB +: pcc_pkg::CTRL_MODE_W] = st_r.mode;
				old_v[pcc_pkg::CTRL_EDGE_POL_BIT] = st_r.edge_polarity_select;
				old_v[pcc_pkg::CTRL_BUS_SEL_BIT] = st_r.bus_sel;
				new_v = pcc_merge(old_v, st_r.wdata, st_r.wstrb);
				st_nxt.mode = new_v[pcc_pkg::CTRL_MODE_LSB +: pcc_pkg::CTRL_MODE_W];
				st_nxt.edge_polarity_select = new_v[pcc_pkg::CTRL_EDGE_POL_BIT];
				st_nxt.bus_sel = new_v[pcc_pkg::CTRL_BUS_SEL_BIT];
				// Any control write restarts the sequencer; zero also parks it in input mode
				st_nxt.state = pcc_pkg::ST_FIRST;
			end
			else if (st_r.awaddr == pcc_pkg::OFS_STATUS)
			begin
				// Write one clears; a capture in the same cycle wins
				if (st_r.wstrb[0] && st_r.wdata[pcc_pkg::STAT_FLAG_BIT])
					st_nxt.channel_event_flag = 1'b0;
			end
			else if (st_r.awaddr == pcc_pkg::OFS_CAP_A || st_r.awaddr == pcc_pkg::OFS_CAP_B)
			begin
				// Captures are read only; writes are ignored
				st_nxt.bresp = pcc_pkg::RESP_OKAY;
			end
			else if (st_r.awaddr == pcc_pkg::OFS_IRQ_MASK)
			begin
				if (st_r.wstrb[0])
					st_nxt.irq_mask = st_r.wdata[pcc_pkg::STAT_FLAG_BIT];
			end
			else if (st_r.awaddr == pcc_pkg::OFS_TB_A_CTRL)
			begin
				new_v = pcc_merge(pcc_tb_word(st_r.tb_a_ctrl), st_r.wdata, st_r.wstrb);
				st_nxt.tb_a_ctrl = new_v[pcc_pkg::TB_CTRL_W-1:0];
			end
			else if (st_r.awaddr == pcc_pkg::OFS_TB_A_MATCH)
			begin
				new_v = pcc_merge({16'h0000, st_r.tb_a_match}, st_r.wdata, st_r.wstrb);
				st_nxt.tb_a_match = new_v[CNT_W-1:0];
			end
			else if (st_r.awaddr == pcc_pkg::OFS_TB_B_CTRL)
			begin
				new_v = pcc_merge(pcc_tb_word(st_r.tb_b_ctrl), st_r.wdata, st_r.wstrb);
				st_nxt.tb_b_ctrl = new_v[pcc_pkg::TB_CTRL_W-1:0];
			end
			else if (st_r.awaddr == pcc_pkg::OFS_TB_B_MATCH)
			begin
				new_v = pcc_merge({16'h0000, st_r.tb_b_match}, st_r.wdata, st_r.wstrb);
				st_nxt.tb_b_match = new_v[CNT_W-1:0];
			end
			else if (st_r.awaddr == pcc_pkg::OFS_TB_A_COUNT || st_r.awaddr == pcc_pkg::OFS_TB_B_COUNT)
			begin
				st_nxt.bresp = pcc_pkg::RESP_OKAY;
			end
			else
			begin
				st_nxt.bresp = pcc_pkg::RESP_SLVERR;
			end
		end

		// Flag set wins over a same-cycle clear
		if (capture_done)
			st_nxt.channel_event_flag = 1'b1;
		st_nxt.irq = st_nxt.channel_event_flag & st_nxt.irq_mask;

		// AXI read: answered on the same edge that takes the address
		if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
		if (s_axi_arvalid && st_r.arready)
		begin
			if (s_axi_araddr == pcc_pkg::OFS_CTRL)
			begin
				rd_v[pcc_pkg::CTRL_MODE_LSB +: pcc_pkg::CTRL_MODE_W] = st_r.mode;
				rd_v[pcc_pkg::CTRL_EDGE_POL_BIT] = st_r.edge_polarity_select;
				rd_v[pcc_pkg::CTRL_BUS_SEL_BIT] = st_r.bus_sel;
			end
			else if (s_axi_araddr == pcc_pkg::OFS_STATUS)
			begin
				rd_v[pcc_pkg::STAT_FLAG_BIT] = st_r.channel_event_flag;
				rd_v[pcc_pkg::STAT_PIN_BIT] = st_r.pin_lvl;
			end
			else if (s_axi_araddr == pcc_pkg::OFS_CAP_A)
				rd_v[CNT_W-1:0] = st_r.cap_a;
			else if (s_axi_araddr == pcc_pkg::OFS_CAP_B)
				rd_v[CNT_W-1:0] = st_r.cap_b;
			else if (s_axi_araddr == pcc_pkg::OFS_IRQ_MASK)
				rd_v[pcc_pkg::STAT_FLAG_BIT] = st_r.irq_mask;
			else if (s_axi_araddr == pcc_pkg::OFS_TB_A_CTRL)
				rd_v = pcc_tb_word(st_r.tb_a_ctrl);
			else if (s_axi_araddr == pcc_pkg::OFS_TB_A_MATCH)
				rd_v[CNT_W-1:0] = st_r.tb_a_match;
			else if (s_axi_araddr == pcc_pkg::OFS_TB_A_COUNT)
				rd_v[CNT_W-1:0] = bus_a;
			else if (s_axi_araddr == pcc_pkg::OFS_TB_B_CTRL)
				rd_v = pcc_tb_word(st_r.tb_b_ctrl);
			else if (s_axi_araddr == pcc_pkg::OFS_TB_B_MATCH)
				rd_v[CNT_W-1:0] = st_r.tb_b_match;
			else if (s_axi_araddr == pcc_pkg::OFS_TB_B_COUNT)
				rd_v[CNT_W-1:0] = bus_b;
			else
				rd_err = 1'b1;
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_v;
			st_nxt.rresp = rd_err ? pcc_pkg::RESP_SLVERR : pcc_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_r.sync <= '0;
			st_r.pin_lvl <= 1'b0;
			st_r.state <= pcc_pkg::ST_FIRST;
			st_r.mode <= pcc_pkg::MODE_GP_INPUT;
			st_r.edge_polarity_select <= 1'b0;
			st_r.bus_sel <= 1'b0;
			st_r.cap_a <= '0;
			st_r.cap_b <= '0;
			st_r.channel_event_flag <= 1'b0;
			st_r.irq_mask <= 1'b0;
			st_r.irq <= 1'b0;
			st_r.tb_a_ctrl <= pcc_pkg::TB_CTRL_RST;
			st_r.tb_a_match <= pcc_pkg::MATCH_RST;
			st_r.tb_b_ctrl <= pcc_pkg::TB_CTRL_RST;
			st_r.tb_b_match <= pcc_pkg::MATCH_RST;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.aw_held <= 1'b0;
			st_r.w_held <= 1'b0;
			st_r.awaddr <= '0;
			st_r.wdata <= '0;
			st_r.wstrb <= '0;
			st_r.bvalid <= 1'b0;
			st_r.bresp <= pcc_pkg::RESP_OKAY;
			st_r.arready <= 1'b1;
			st_r.rvalid <= 1'b0;
			st_r.rresp <= pcc_pkg::RESP_OKAY;
			st_r.rdata <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign irq = st_r.irq;

endmodule // pcc_channel

// ### test/pcc_channel_checker.sv
// Bus-side checker for the capture channel top.
// Assumes it is bound to the top and sees only its ports; one clock domain.
module pcc_channel_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// Read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed before bready");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
		else $error("read response dropped or changed before rready");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while response pending");
	a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
		else $error("write channel not released after response");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
		else $error("read channel not released after response");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == pcc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read returned nonzero data");
endmodule // pcc_channel_checker

// ### test/pcc_pulse_src.sv
// Behavioural pulse source standing in for the signal on the measured pin.
// Assumes the bench clock; en low freezes the level so no stray edge appears.
module pcc_pulse_src (
	// Clock
	input wire logic clk_sys,
	// Control
	input wire logic en,
	input wire logic [7:0] hi_len,
	input wire logic [7:0] lo_len,
	// Pin
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_r = 8'h01;
	initial pin = 1'b0;
	// Reload on freeze so new lengths take effect from the first edge
	always @(posedge clk_sys)
		if (!en)
			cnt_r <= 8'h01;
		else if (cnt_r <= 8'h01)
		begin
			pin <= ~pin;
			cnt_r <= pin ? lo_len : hi_len;
		end
		else
			cnt_r <= cnt_r - 8'h01;
endmodule // pcc_pulse_src

// ### test/pcc_channel_tb.sv
// Self-checking bench for the capture channel: bus master, pulse source, checks.
// Assumes a 200 MHz clock and the register map of the channel package.
module pcc_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, pin_in, src_en, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, hi_len, lo_len;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rresp_seen;
	logic [15:0] a, b;
	logic [31:0] cfg [4] = '{32'h81, 32'h01, 32'h82, 32'h02};
	integer seed = 19282;
	int miscompares = 0;
	int total_checks = 0;
	int h, l;

	pcc_channel pcc_channel_i (.clk_sys, .rst_n, .pin_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .irq);
	pcc_pulse_src pcc_pulse_src_i (.clk_sys, .en(src_en), .hi_len, .lo_len, .pin(pin_in));

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
		logic aw, w, bd;
		int lag;
		aw = 1'b0;
		w = 1'b0;
		bd = 1'b0;
		// Random ready lag of 0 to 2 cycles ends no later than bvalid rises, so no response is held
		lag = {$random(seed)} % 3;
		@(posedge clk_sys);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= ad;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= dt;
		s_axi_bready <= (lag == 0);
		while (!bd)
		begin
			@(posedge clk_sys);
			lag--;
			if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			begin
				bd = 1'b1;
				s_axi_bready <= 1'b0;
				chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
			end
			else if (lag <= 0)
				s_axi_bready <= 1'b1;
			if (!aw && s_axi_awready === 1'b1)
			begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1)
			begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
		logic ar, rd_done;
		int lag;
		ar = 1'b0;
		rd_done = 1'b0;
		lag = {$random(seed)} % 3;
		@(posedge clk_sys);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= ad;
		s_axi_rready <= (lag == 0);
		while (!rd_done)
		begin
			@(posedge clk_sys);
			lag--;
			if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			begin
				rd_done = 1'b1;
				dt = s_axi_rdata;
				rresp_seen = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
			else if (lag <= 0)
				s_axi_rready <= 1'b1;
			if (!ar && s_axi_arready === 1'b1)
			begin
				ar = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
	endtask

	task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] dt;
		rd(ad, dt);
		chk(nm, dt & m, e);
	endtask

	// Software sequence: restart, clear flag, wait for a fresh flag, then read
	task automatic measure(input logic [31:0] c, output logic [15:0] ca, output logic [15:0] cb);
		logic [31:0] dt;
		int n;
		src_en <= 1'b1;
		wr(pcc_pkg::OFS_CTRL, 32'h0, pcc_pkg::RESP_OKAY);
		wr(pcc_pkg::OFS_CTRL, c, pcc_pkg::RESP_OKAY);
		wr(pcc_pkg::OFS_STATUS, 32'h1, pcc_pkg::RESP_OKAY);
		n = 0;
		while (irq !== 1'b1 && n < 1000)
		begin
			@(posedge clk_sys);
			n++;
		end
		src_en <= 1'b0;
		chk("irq_done", {31'h0, irq}, 32'h1);
		rd(pcc_pkg::OFS_CAP_A, dt);
		ca = dt[15:0];
		rd(pcc_pkg::OFS_CAP_B, dt);
		cb = dt[15:0];
	endtask

	function automatic logic [15:0] span(input logic [31:0] c, input int hl, input int ll);
		if (c[3:0] == pcc_pkg::MODE_PERIOD)
			return 16'(hl + ll);
		return c[7] ? 16'(hl) : 16'(ll);
	endfunction

	initial
	begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		stop_test;
	end

	initial
	begin
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, src_en} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
		s_axi_wstrb = 4'hf;
		hi_len = 8'd20;
		lo_len = 8'd20;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rc("ctrl_rst", pcc_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
		rc("flag_rst", pcc_pkg::OFS_STATUS, 32'h1, 32'h0);
		rc("match_rst", pcc_pkg::OFS_TB_A_MATCH, 32'hffff, 32'hffff);
		rc("cap_rst", pcc_pkg::OFS_CAP_A, 32'hffff, 32'h0);
		wr(8'h2c, 32'h5, pcc_pkg::RESP_SLVERR);
		rc("unmapped", 8'h2c, 32'hffffffff, 32'h0);
		chk("unmapped_resp", {30'h0, rresp_seen}, {30'h0, pcc_pkg::RESP_SLVERR});
		wr(pcc_pkg::OFS_TB_A_MATCH, 32'h9, pcc_pkg::RESP_OKAY);
		wr(pcc_pkg::OFS_TB_A_CTRL, 32'h100, pcc_pkg::RESP_OKAY);
		repeat (6)
		begin
			rd(pcc_pkg::OFS_TB_A_COUNT, d);
			chk("count_wrap", {31'h0, d <= 32'h9}, 32'h1);
		end
		wr(pcc_pkg::OFS_TB_A_MATCH, 32'hffff, pcc_pkg::RESP_OKAY);
		wr(pcc_pkg::OFS_IRQ_MASK, 32'h1, pcc_pkg::RESP_OKAY);
		src_en <= 1'b1;
		wr(pcc_pkg::OFS_STATUS, 32'h1, pcc_pkg::RESP_OKAY);
		repeat (200) @(posedge clk_sys);
		rc("input_mode_idle", pcc_pkg::OFS_STATUS, 32'h1, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			h = 12 + {$random(seed)} % 30;
			l = 12 + {$random(seed)} % 30;
			hi_len <= 8'(h);
			lo_len <= 8'(l);
			measure(cfg[i % 4], a, b);
			chk("span", {16'h0, a - b}, {16'h0, span(cfg[i % 4], h, l)});
		end
		rc("flag_set", pcc_pkg::OFS_STATUS, 32'h1, 32'h1);
		wr(pcc_pkg::OFS_STATUS, 32'h0, pcc_pkg::RESP_OKAY);
		rc("flag_kept", pcc_pkg::OFS_STATUS, 32'h1, 32'h1);
		wr(pcc_pkg::OFS_IRQ_MASK, 32'h0, pcc_pkg::RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(pcc_pkg::OFS_IRQ_MASK, 32'h1, pcc_pkg::RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk("irq_unmasked", {31'h0, irq}, 32'h1);
		wr(pcc_pkg::OFS_STATUS, 32'h1, pcc_pkg::RESP_OKAY);
		rc("flag_clr", pcc_pkg::OFS_STATUS, 32'h1, 32'h0);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		rc("pin_level", pcc_pkg::OFS_STATUS, 32'h2, {30'h0, pin_in, 1'b0});
		// Bus B never started, so both captures must hold its idle count
		measure(32'h181, a, b);
		chk("bus_b_sel", {a, b}, 32'h0);
		stop_test;
	end
endmodule // pcc_channel_tb

bind pcc_channel pcc_channel_checker pcc_channel_checker_i (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
